// ===== logic/serial_port_strap_config.sv
// Reset-time strap capture and port/lane configuration for the switch
//
// How it works
// - Ports numbered 0 to 7 everywhere
// - Mode strap 0 wide, 1 two narrow
// - Narrow: lane A port n, B n+1
// - Lanes C, D only on wide 0/6
// - Strap changes ignored after sampling
// - Even strap 1 powers down both ports
// - Even power-down covers all four lanes
// - Odd strap powers narrow odd port down/up
// - Software overrides both power-down states
// - Strap drivers enabled only in test mode
// - Bit 0 is MSB on all ports but reg_addr
// - Hard reset asynchronous, active low
`timescale 1ns/1ns
module serial_port_strap_config
  import strap_cfg_pkg::*;
(
  input  wire logic               clk_sys,        // Bus clock, 10 MHz
  input  wire logic               srst,           // Sync reset, high
  input  wire logic               ce,             // Clock enable
  input  wire logic               device_reset_n, // Hard reset pin
  input  wire logic               test_mode,      // Test mode pin
  input  wire logic [0:9]         test_strap_out, // Test drive values
  input  wire logic [0:1]         pair_lane_mode_strap_i,     // Mode in
  output logic      [0:1]         pair_lane_mode_strap_o,     // Mode out
  output logic      [0:1]         pair_lane_mode_strap_oe,    // Mode oe
  input  wire logic [0:3]         even_port_powerdown_strap_i,  // Even in
  output logic      [0:3]         even_port_powerdown_strap_o,  // Even out
  output logic      [0:3]         even_port_powerdown_strap_oe, // Even oe
  input  wire logic [0:3]         odd_port_powerdown_strap_i,   // Odd in
  output logic      [0:3]         odd_port_powerdown_strap_o,   // Odd out
  output logic      [0:3]         odd_port_powerdown_strap_oe,  // Odd oe
  input  wire logic [ADDR_W-1:0]  reg_addr,       // Register address
  input  wire logic [0:DATA_W-1]  reg_wdata,      // Write data
  input  wire logic               reg_wr,         // Write strobe
  input  wire logic               reg_rd,         // Read strobe
  output logic      [0:DATA_W-1]  reg_rdata,      // Read data
  output logic                    config_done,    // Straps latched
  output logic      [0:7]         port_powered_down, // Per port off
  output logic      [0:7]         port_wide_mode,    // Port runs 4 lanes
  output logic      [0:3]         block_powerdown,   // Whole block off
  output logic      [0:11]        lane_a_port_num,   // Owner of lane A
  output logic      [0:11]        lane_b_port_num,   // Owner of lane B
  output logic      [0:1]         lane_cd_enable     // Lanes C/D carry
);

  // Pin synchronisers
  logic [0:1]  mode_sync;
  logic [0:3]  even_sync;
  logic [0:3]  odd_sync;
  logic [0:0]  test_sync;

  strap_sync #(.WIDTH(2)) u_mode_sync (
    .clk_sys  (clk_sys),
    .ce       (ce),
    .async_in (pair_lane_mode_strap_i),
    .sync_out (mode_sync)
  );

  strap_sync #(.WIDTH(4)) u_even_sync (
    .clk_sys  (clk_sys),
    .ce       (ce),
    .async_in (even_port_powerdown_strap_i),
    .sync_out (even_sync)
  );

  strap_sync #(.WIDTH(4)) u_odd_sync (
    .clk_sys  (clk_sys),
    .ce       (ce),
    .async_in (odd_port_powerdown_strap_i),
    .sync_out (odd_sync)
  );

  strap_sync #(.WIDTH(1)) u_test_sync (
    .clk_sys  (clk_sys),
    .ce       (ce),
    .async_in (test_mode),
    .sync_out (test_sync)
  );

  // Hard reset: asserts at once, releases through two flops
  logic rst_meta_r;
  logic rst_rel_r;

  always_ff @(posedge clk_sys or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_rel_r  <= 1'b0;
    end
    else if (ce)
    begin
      rst_meta_r <= 1'b1;
      rst_rel_r  <= rst_meta_r;
    end
  end

  // Returns the port number that owns a lane of a pair
  function automatic logic [PORT_NUM_W-1:0] lane_owner(
    input logic [1:0] pair,
    input logic       lane_b,
    input logic       split
  );
    logic [PORT_NUM_W-1:0] base;
    base = {pair, 1'b0};
    lane_owner = (lane_b && split) ? (base | 3'h1) : base;
  endfunction

  // Sampling sequencer
  cfg_state_e  state_r;
  cfg_state_e  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;

  wire sample_now = (state_r == ST_SAMPLE) && (cnt_r == SAMPLE_CNT);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_WAIT:
      begin
        cnt_nxt = 4'h0;
        if (rst_rel_r)
          state_nxt = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (sample_now)
          state_nxt = ST_RUN;
      end
      ST_RUN:
        cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge clk_sys or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      state_r <= ST_WAIT;
      cnt_r   <= 4'h0;
    end
    else if (srst)
    begin
      state_r <= ST_WAIT;
      cnt_r   <= 4'h0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Latched straps and software power-down fields
  logic [0:1] mode_r;
  logic [0:3] strap_even_r;
  logic [0:3] strap_odd_r;
  logic [0:3] even_pd_r;
  logic [0:3] odd_pd_r;
  logic [0:3] even_pd_nxt;
  logic [0:3] odd_pd_nxt;

  // Register decode
  wire       run      = (state_r == ST_RUN);
  wire       hit_csel = (reg_addr[7:4] == 4'h0) && (reg_addr[1:0] == 2'h0);
  wire [1:0] csel_idx = reg_addr[3:2];
  wire       hit_stat = (reg_addr == REG_STATUS);
  wire       hit_pcfg = (reg_addr == REG_PORTCFG);
  // Writes before the straps land would be lost to sampling anyway
  wire       csel_we  = reg_wr && hit_csel && run;

  always_comb
  begin
    even_pd_nxt = even_pd_r;
    odd_pd_nxt  = odd_pd_r;
    if (sample_now)
    begin
      even_pd_nxt = even_sync;
      odd_pd_nxt  = odd_sync;
    end
    else if (csel_we)
    begin
      even_pd_nxt[csel_idx] = reg_wdata[CLKSEL_EVEN_PD_BIT];
      odd_pd_nxt[csel_idx]  = reg_wdata[CLKSEL_ODD_PD_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      mode_r       <= MODE_RESET;
      strap_even_r <= PD_RESET;
      strap_odd_r  <= PD_RESET;
      even_pd_r    <= PD_RESET;
      odd_pd_r     <= PD_RESET;
    end
    else if (srst)
    begin
      mode_r       <= MODE_RESET;
      strap_even_r <= PD_RESET;
      strap_odd_r  <= PD_RESET;
      even_pd_r    <= PD_RESET;
      odd_pd_r     <= PD_RESET;
    end
    else if (ce)
    begin
      if (sample_now)
      begin
        mode_r       <= mode_sync;
        strap_even_r <= even_sync;
        strap_odd_r  <= odd_sync;
      end
      even_pd_r <= even_pd_nxt;
      odd_pd_r  <= odd_pd_nxt;
    end
  end

  // Derived port and lane configuration
  wire [0:3] pair_split = {mode_r[0], MODE_SPLIT, MODE_SPLIT, mode_r[1]};
  logic [0:7]  port_pd_nxt;
  logic [0:7]  port_wide_nxt;
  logic [0:11] lane_a_nxt;
  logic [0:11] lane_b_nxt;
  logic [0:1]  lane_cd_nxt;

  always_comb
  begin
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      port_pd_nxt[2*p]     = even_pd_r[p] || !run;
      // Odd port is dead in wide mode, so keep it off
      port_pd_nxt[2*p+1]   = even_pd_r[p] || odd_pd_r[p] || !run ||
                             (pair_split[p] == MODE_WIDE);
      port_wide_nxt[2*p]   = run && (pair_split[p] == MODE_WIDE);
      port_wide_nxt[2*p+1] = 1'b0;
      lane_a_nxt[3*p +: 3] = lane_owner(2'(p), 1'b0, pair_split[p]);
      lane_b_nxt[3*p +: 3] = lane_owner(2'(p), 1'b1, pair_split[p]);
    end
    // Only the blocks for ports 0 and 6 own lanes C and D
    lane_cd_nxt[0] = run && (mode_r[0] == MODE_WIDE) && !even_pd_r[0];
    lane_cd_nxt[1] = run && (mode_r[1] == MODE_WIDE) && !even_pd_r[3];
  end

  always_ff @(posedge clk_sys or negedge device_reset_n)
  begin
    if (!device_reset_n)
    begin
      port_powered_down <= 8'hFF;
      port_wide_mode    <= 8'h00;
      block_powerdown   <= PD_RESET;
      lane_a_port_num   <= 12'h000;
      lane_b_port_num   <= 12'h000;
      lane_cd_enable    <= 2'h0;
      config_done       <= 1'b0;
    end
    else if (srst)
    begin
      port_powered_down <= 8'hFF;
      port_wide_mode    <= 8'h00;
      block_powerdown   <= PD_RESET;
      lane_a_port_num   <= 12'h000;
      lane_b_port_num   <= 12'h000;
      lane_cd_enable    <= 2'h0;
      config_done       <= 1'b0;
    end
    else if (ce)
    begin
      port_powered_down <= port_pd_nxt;
      port_wide_mode    <= port_wide_nxt;
      block_powerdown   <= even_pd_r | {4{!run}};
      lane_a_port_num   <= lane_a_nxt;
      lane_b_port_num   <= lane_b_nxt;
      lane_cd_enable    <= lane_cd_nxt;
      config_done       <= run;
    end
  end

  // Read data: mirrors of power-down fields, strap and port state
  logic [0:DATA_W-1] csel_word;
  logic [0:DATA_W-1] stat_word;
  logic [0:DATA_W-1] pcfg_word;
  logic [0:DATA_W-1] rd_mux;

  always_comb
  begin
    csel_word = '0;
    csel_word[CLKSEL_EVEN_PD_BIT] = even_pd_r[csel_idx];
    csel_word[CLKSEL_ODD_PD_BIT]  = odd_pd_r[csel_idx];
    stat_word = '0;
    stat_word[STATUS_DONE_BIT]  = run;
    stat_word[STATUS_MODE0_BIT] = mode_r[0];
    stat_word[STATUS_MODE3_BIT] = mode_r[1];
    stat_word[STATUS_TEST_BIT]  = test_sync[0];
    stat_word[STATUS_STRAP_PD_LO +: 8] =
      {strap_even_r[0], strap_odd_r[0], strap_even_r[1], strap_odd_r[1],
       strap_even_r[2], strap_odd_r[2], strap_even_r[3], strap_odd_r[3]};
    pcfg_word = '0;
    pcfg_word[PORTCFG_WIDE_LO +: 8] = port_wide_mode;
    pcfg_word[PORTCFG_PD_LO +: 8]   = port_powered_down;
    if (hit_csel)
      rd_mux = csel_word;
    else if (hit_stat)
      rd_mux = stat_word;
    else if (hit_pcfg)
      rd_mux = pcfg_word;
    else
      rd_mux = '0;
  end

  // Read data stands in the cycle after each cycle with reg_rd high, zero otherwise
  always_ff @(posedge clk_sys or negedge device_reset_n)
  begin
    if (!device_reset_n)
      reg_rdata <= '0;
    else if (srst)
      reg_rdata <= '0;
    else if (ce)
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

  // Strap pins are inputs except in test mode
  wire drive_en = test_sync[0];

  assign pair_lane_mode_strap_o       = test_strap_out[0:1];
  assign even_port_powerdown_strap_o  = test_strap_out[2:5];
  assign odd_port_powerdown_strap_o   = test_strap_out[6:9];
  assign pair_lane_mode_strap_oe      = {2{drive_en}};
  assign even_port_powerdown_strap_oe = {4{drive_en}};
  assign odd_port_powerdown_strap_oe  = {4{drive_en}};

endmodule

// ===== logic/strap_cfg_pkg.sv
// Constants, register map and state type for the strap configuration loader
package strap_cfg_pkg;

  // Port numbering, bit 0 is the most significant bit on every module port but reg_addr
  localparam int NUM_PORTS     = 8;
  localparam int NUM_PAIRS     = 4;
  localparam int NUM_WIDE      = 2;
  localparam int PORT_NUM_W    = 3;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // Strap hold window after hard reset release, in bus clock cycles
  localparam logic [3:0] STRAP_HOLD_CYCLES = 4'hA;
  // Pipeline ahead of the sample point: reset sync plus the ST_WAIT cycle
  localparam logic [3:0] SYNC_LATENCY      = 4'h3;
  localparam logic [3:0] SAMPLE_CNT        = STRAP_HOLD_CYCLES - SYNC_LATENCY;

  // Mode strap values
  localparam logic MODE_WIDE   = 1'b0;
  localparam logic MODE_SPLIT  = 1'b1;

  // Register byte offsets
  localparam logic [7:0] REG_CLKSEL0  = 8'h00;
  localparam logic [7:0] REG_CLKSEL1  = 8'h04;
  localparam logic [7:0] REG_CLKSEL2  = 8'h08;
  localparam logic [7:0] REG_CLKSEL3  = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_PORTCFG  = 8'h14;

  // Clock selection register fields
  localparam int CLKSEL_EVEN_PD_BIT = 30;
  localparam int CLKSEL_ODD_PD_BIT  = 31;

  // Status register fields
  localparam int STATUS_DONE_BIT    = 31;
  localparam int STATUS_MODE0_BIT   = 30;
  localparam int STATUS_MODE3_BIT   = 29;
  localparam int STATUS_TEST_BIT    = 28;
  localparam int STATUS_STRAP_PD_LO = 16;

  // Port configuration register fields
  localparam int PORTCFG_WIDE_LO    = 16;
  localparam int PORTCFG_PD_LO      = 24;

  // Values held before sampling completes: ports off, 1-lane mode
  localparam logic [0:3] PD_RESET   = 4'hF;
  localparam logic [0:1] MODE_RESET = 2'h3;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_SAMPLE,
    ST_RUN
  } cfg_state_e;

endpackage

// ===== logic/strap_sync.sv
// Two-stage synchroniser bank for asynchronous strap pins
`timescale 1ns/1ns
module strap_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,  // Bus clock
  input  wire logic             ce,       // Clock enable
  input  wire logic [0:WIDTH-1] async_in, // Pin levels
  output logic      [0:WIDTH-1] sync_out  // Synchronised levels
);

  logic [0:WIDTH-1] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== tb/strap_board.sv
// Board strap resistors and power-up reset source
`timescale 1ns/1ns
module strap_board (
  input  wire logic       clk_sys,        // Clock
  input  wire logic       power_up,       // Low holds hard reset
  input  wire logic       wiggle,         // Move straps after hold
  input  wire logic [0:9] cfg,            // Pull levels, bit 0 first
  input  wire logic [0:9] pin_o,          // Device drive
  input  wire logic [0:9] pin_oe,         // Device enable
  output logic            device_reset_n, // Hard reset
  output logic      [0:9] pin             // Pin levels
);
  logic [3:0] hold_r;
  logic [0:9] pull;

  always_ff @(posedge clk_sys)
  begin
    if (!power_up)
      hold_r <= 4'h0;
    else if (hold_r != 4'hF)
      hold_r <= hold_r + 4'h1;
  end

  assign device_reset_n = power_up;
  // Wide pair straps its odd port off
  assign pull = cfg | {6'h00, ~cfg[0], 2'h0, ~cfg[1]};
  // Levels only move once more than ten clocks have passed
  assign pin = (pin_oe & pin_o) | (~pin_oe
    & ((wiggle && hold_r > 4'hA) ? ~pull : pull));
endmodule

// ===== tb/serial_port_strap_config_checker.sv
// Port assertions for the strap configuration loader
`timescale 1ns/1ns
module serial_port_strap_config_checker (
  input wire logic        clk_sys,                      // Clock
  input wire logic        srst,                         // Reset
  input wire logic        device_reset_n,               // Hard reset
  input wire logic        test_mode,                    // Test pin
  input wire logic [0:1]  pair_lane_mode_strap_oe,      // Mode oe
  input wire logic [0:3]  even_port_powerdown_strap_oe, // Even oe
  input wire logic [0:3]  odd_port_powerdown_strap_oe,  // Odd oe
  input wire logic        config_done,                  // Latched
  input wire logic [0:7]  port_powered_down,            // Port off
  input wire logic [0:7]  port_wide_mode,               // Four lanes
  input wire logic [0:11] lane_a_port_num,              // Lane A owner
  input wire logic [0:11] lane_b_port_num,              // Lane B owner
  input wire logic [0:1]  lane_cd_enable                // Lanes C/D
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_release;
    $rose(device_reset_n);
  endsequence
  sequence s_settle;
    !config_done [*8] ##[1:8] config_done;
  endsequence

  a_latch_window: assert property (
    s_release |-> s_settle) else $error("latch out of window");
  a_hard_reset: assert property (
    !device_reset_n |-> !config_done && port_powered_down == 8'hFF)
    else $error("hard reset not holding");
  a_done_held: assert property (
    disable iff (srst || !device_reset_n) config_done |=> config_done)
    else $error("done dropped");
  a_cfg_frozen: assert property (
    disable iff (srst || !device_reset_n) config_done |=>
    $stable(port_wide_mode) && $stable(lane_b_port_num))
    else $error("mode moved after latch");
  a_test_only: assert property (
    !test_mode [*3] |-> ~|{pair_lane_mode_strap_oe,
    even_port_powerdown_strap_oe, odd_port_powerdown_strap_oe})
    else $error("strap driver on");
  a_even_off: assert property (
    ((port_powered_down >> 1) & ~port_powered_down & 8'h55) == 8'h00)
    else $error("odd up under even down");
  a_wide_odd: assert property (
    port_wide_mode[0] |-> port_powered_down[1]) else $error("odd up");
  a_lane_owner: assert property (
    config_done |-> lane_a_port_num[3:5] == 3'h2
    && lane_b_port_num[0:2] == (port_wide_mode[0] ? 3'h0 : 3'h1))
    else $error("lane owner wrong");
  a_cd_wide: assert property (
    lane_cd_enable[0] |-> port_wide_mode[0] && !port_powered_down[0])
    else $error("lanes C/D live");
endmodule

bind serial_port_strap_config serial_port_strap_config_checker i_chk (
  .clk_sys, .srst, .device_reset_n, .test_mode, .pair_lane_mode_strap_oe,
  .even_port_powerdown_strap_oe, .odd_port_powerdown_strap_oe,
  .config_done, .port_powered_down, .port_wide_mode, .lane_a_port_num,
  .lane_b_port_num, .lane_cd_enable);

// ===== tb/serial_port_strap_config_tb.sv
// Self-checking bench for the strap configuration loader
`timescale 1ns/1ns
module serial_port_strap_config_tb
  import strap_cfg_pkg::*;
;
  logic        clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, test_mode = 1'b0;
  logic        power_up = 1'b0, wiggle = 1'b0, reg_wr = 1'b0;
  logic        reg_rd = 1'b0, device_reset_n, config_done;
  logic [7:0]  reg_addr = 8'h00;
  logic [0:31] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [0:9]  test_strap_out = 10'h000, cfg = 10'h000, pin;
  logic [0:1]  pair_lane_mode_strap_i, pair_lane_mode_strap_o;
  logic [0:1]  pair_lane_mode_strap_oe, lane_cd_enable;
  logic [0:3]  even_port_powerdown_strap_i, even_port_powerdown_strap_o;
  logic [0:3]  even_port_powerdown_strap_oe, odd_port_powerdown_strap_i;
  logic [0:3]  odd_port_powerdown_strap_o, odd_port_powerdown_strap_oe;
  logic [0:3]  block_powerdown;
  logic [0:7]  port_powered_down, port_wide_mode;
  logic [0:11] lane_a_port_num, lane_b_port_num;
  int          fail_count = 0, samples_checked = 0;
  wire  [0:9]  oe_all = {pair_lane_mode_strap_oe,
    even_port_powerdown_strap_oe, odd_port_powerdown_strap_oe};
  wire  [0:9]  o_all = {pair_lane_mode_strap_o,
    even_port_powerdown_strap_o, odd_port_powerdown_strap_o};

  assign pair_lane_mode_strap_i      = pin[0:1];
  assign even_port_powerdown_strap_i = pin[2:5];
  assign odd_port_powerdown_strap_i  = pin[6:9];

  serial_port_strap_config i_serial_port_strap_config (
    .clk_sys, .srst, .ce, .device_reset_n, .test_mode, .test_strap_out,
    .pair_lane_mode_strap_i, .pair_lane_mode_strap_o,
    .pair_lane_mode_strap_oe, .even_port_powerdown_strap_i,
    .even_port_powerdown_strap_o, .even_port_powerdown_strap_oe,
    .odd_port_powerdown_strap_i, .odd_port_powerdown_strap_o,
    .odd_port_powerdown_strap_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .config_done, .port_powered_down, .port_wide_mode,
    .block_powerdown, .lane_a_port_num, .lane_b_port_num, .lane_cd_enable);
  strap_board i_strap_board (.clk_sys, .power_up, .wiggle, .cfg,
    .pin_o(o_all), .pin_oe(oe_all), .device_reset_n, .pin);

  always #50 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [0:31] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
    @(posedge clk_sys);
    #1 check(reg_rdata, 32'h0000_0000);
  endtask

  // Waits for the latch, then rebuilds every done, port and lane output from the straps
  task automatic settle(input logic [0:9] c);
    logic [0:7]  pd, wm;
    logic [0:3]  bp;
    logic [0:11] la, lb;
    logic        wide;
    for (int n = 0; n < 40 && config_done !== 1'b1; n++)
      @(posedge clk_sys);
    #1;
    for (int k = 0; k < 4; k++)
    begin
      wide = (k == 0 && !c[0]) || (k == 3 && !c[1]);
      pd[2*k] = c[2+k];
      pd[2*k+1] = c[2+k] | c[6+k] | wide;
      wm[2*k] = wide;
      wm[2*k+1] = 1'b0;
      bp[k] = c[2+k];
      la[3*k +: 3] = 3'(2*k);
      lb[3*k +: 3] = wide ? 3'(2*k) : 3'(2*k+1);
    end
    check(config_done, 1'b1);
    check(port_powered_down, pd);
    check(port_wide_mode, wm);
    check(block_powerdown, bp);
    check(lane_a_port_num, la);
    check(lane_b_port_num, lb);
    check(lane_cd_enable, {!c[0] && !c[2], !c[1] && !c[5]});
  endtask

  task automatic boot(input logic [0:9] c);
    @(posedge clk_sys);
    power_up <= 1'b0;
    cfg      <= c;
    repeat (3) @(posedge clk_sys);
    power_up <= 1'b1;
    settle(c);
  endtask

  task automatic t_wide;
    boot(10'h000);
    @(posedge clk_sys);
    wiggle <= 1'b1;
    repeat (20) @(posedge clk_sys);
    settle(10'h000);
    test_strap_out <= 10'h2A5;
    test_mode      <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check(oe_all, 32'h3FF);
    check(o_all, 32'h2A5);
    check(pin, 32'h2A5);
    @(posedge clk_sys);
    test_mode <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check(oe_all, 32'h000);
    // Clearing the odd field cannot wake a port a wide pair swallows
    bus_wr(REG_CLKSEL0, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    settle(10'h000);
    wiggle <= 1'b0;
    $display("t_wide finished");
  endtask

  task automatic t_split;
    boot(10'h352);
    bus_rd(REG_STATUS, 32'h0000_2607);
    bus_rd(REG_CLKSEL1, 32'h0000_0002);
    bus_wr(REG_CLKSEL1, 32'h0000_0000);
    bus_wr(REG_CLKSEL0, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1 check(port_powered_down, 8'h47);
    bus_rd(REG_PORTCFG, 32'h0000_0047);
    bus_rd(8'h20, 32'h0000_0000);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    // Clock enable low freezes sampling as well
    ce   <= 1'b0;
    #1 check(config_done, 1'b0);
    check(port_powered_down, 8'hFF);
    repeat (15) @(posedge clk_sys);
    ce <= 1'b1;
    #1 check(config_done, 1'b0);
    settle(10'h352);
    $display("t_split finished");
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    t_wide;
    t_split;
    wrap_up;
  end

  initial
  begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    wrap_up;
  end
endmodule
